// file: cfm_config_fuse_map.sv
// Function
// - programmed bit reads 0, erased reads 1
// - words from 0xF80000 at even addresses
// - config space reachable only by table access
// - unimplemented bits read as 0
// - absent secure word reads 0xFF
// - power-on reserved upper bits read 1
// - power-up timer period selectable 0 or 2..128 ms
// - wait 1024 oscillator periods at start
`timescale 1ns/1ps
`default_nettype none
module cfm_config_fuse_map
	import cfm_pkg::*;
#(
	// Clock cycles per ms of power-up delay; shorten in simulation
	parameter int PWRT_CYC_PER_MS = CFM_CYC_PER_MS
)
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic osc_i,
	input wire logic small_variant_i,
	input wire logic tbl_rd_i,
	input wire logic tbl_wr_i,
	input wire logic [CFM_AW-1:0] tbl_addr_i,
	input wire logic [CFM_DW-1:0] tbl_wdata_i,
	output logic [CFM_DW-1:0] tbl_rdata_o,
	output logic tbl_ack_o,
	output logic tbl_err_o,
	output logic [CFM_IW-1:0] nv_addr_o,
	input wire logic [CFM_DW-1:0] nv_rdata_i,
	output logic nv_wr_o,
	output logic [CFM_DW-1:0] nv_wdata_o,
	output logic [CFM_NWORDS*CFM_DW-1:0] cfg_words_o,
	output logic osc_valid_o,
	output logic sys_rst_n_o
);

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		cfm_state_type st; // Start-up sequencer
		logic [11:0][7:0] words; // Stored configuration words
		logic [7:0] rdata; // Table read answer
		logic ack; // Table access answered
		logic err; // Table access refused
		logic [3:0] nv_addr; // Storage word index
		logic nv_wr; // Storage write strobe
		logic [7:0] nv_wdata; // Storage write data
		logic [95:0] cfg; // Effective words to the control logic
		logic osc_valid; // Oscillator has settled
		logic sys_rst_n; // Device reset release
		logic osc_d; // Delayed oscillator level for edges
	} cfm_core_type;

	cfm_core_type r;
	cfm_core_type n;

	logic osc_s; // Oscillator after synchroniser
	logic small_s; // Variant strap after synchroniser
	logic ost_load; // Start the start-up wait
	logic pwrt_load; // Start the power-up delay
	logic ost_done; // Start-up wait over
	logic pwrt_done; // Power-up delay over
	logic osc_rise; // One mclk per oscillator period
	logic [CFM_TW-1:0] pwrt_count; // Power-up delay in mclk cycles
	logic hit; // Address names a word
	logic [3:0] hidx; // Index of that word
	logic [11:0][7:0] eff; // Words as software sees them

	////////////////////////////////////////////////////////////////////////
	// Pin inputs cross into mclk
	cfm_sync u_osc_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(osc_i),
		.q_o(osc_s)
	);

	cfm_sync u_small_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i(small_variant_i),
		.q_o(small_s)
	);

	// Edge of the settled oscillator level; the oscillator must run
	// below half of mclk or periods are missed
	assign osc_rise = osc_s && !r.osc_d;

	// Period picked by the power-on word's timer field
	assign pwrt_count = CFM_TW'(
		CFM_PWRT_MS[r.words[CFM_IDX_POR][CFM_PWRT_LSB +: CFM_PWRT_W]] *
		PWRT_CYC_PER_MS);

	////////////////////////////////////////////////////////////////////////
	// Start-up timers: one counts oscillator periods, one mclk cycles
	cfm_timer u_ost (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.load_i(ost_load),
		.count_i(CFM_OST_PERIODS),
		.tick_i(osc_rise),
		.done_o(ost_done)
	);

	cfm_timer u_pwrt (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.load_i(pwrt_load),
		.count_i(pwrt_count),
		.tick_i(1'b1),
		.done_o(pwrt_done)
	);

	////////////////////////////////////////////////////////////////////////
	// Address decode and read-back values
	always_comb
	begin
		hit = 1'b0;
		hidx = '0;
		// Words sit at consecutive even addresses from the base
		for (int i = 0; i < CFM_NWORDS; i++)
		begin
			if (tbl_addr_i == CFM_WORD_ADDR[i])
			begin
				hit = 1'b1;
				hidx = 4'(i);
			end
		end
		for (int i = 0; i < CFM_NWORDS; i++)
		begin
			// Stored bits as-is: programmed 0, erased 1
			// Unimplemented bits masked to 0
			// Reserved power-on bits forced to 1
			eff[i] = (r.words[i] & CFM_IMPL_MASK[i]) | CFM_FORCE_ONE[i];
		end
		// Small variant has no secure word
		if (small_s)
			eff[CFM_IDX_SECURE] = CFM_ABSENT_DATA;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state: sequencer and table access
	always_comb
	begin
		n = r;
		ost_load = 1'b0;
		pwrt_load = 1'b0;
		n.ack = 1'b0;
		n.err = 1'b0;
		n.nv_wr = 1'b0;
		n.osc_d = osc_s;
		n.cfg = eff;
		unique case (r.st)
			CFM_ST_LOAD:
			begin
				// Copy storage word by word; device stays in reset
				n.words[r.nv_addr] = nv_rdata_i;
				if (r.nv_addr == CFM_IDX_LAST)
				begin
					n.st = CFM_ST_OST;
					ost_load = 1'b1;
				end
				else
					n.nv_addr = r.nv_addr + 1'b1;
			end
			CFM_ST_OST:
			begin
				// Clock valid only after the full oscillator wait
				if (ost_done)
				begin
					n.st = CFM_ST_PWRT;
					n.osc_valid = 1'b1;
					pwrt_load = 1'b1;
				end
			end
			CFM_ST_PWRT:
			begin
				// Release reset when the selected period ends
				if (pwrt_done)
				begin
					n.st = CFM_ST_RUN;
					n.sys_rst_n = 1'b1;
				end
			end
			CFM_ST_RUN:
			begin
				// Table access is served from here
			end
		endcase
		if (tbl_rd_i || tbl_wr_i)
		begin
			n.ack = 1'b1;
			n.rdata = '0;
			// Outside the space, or before release: refused
			if (r.st != CFM_ST_RUN || tbl_addr_i < CFM_SPACE_LO)
				n.err = 1'b1;
			else if (tbl_rd_i)
				n.rdata = hit ? eff[hidx] : CFM_UNMAPPED_DATA;
			else if (hit)
			begin
				// Stored as written; the programming agent must keep
				// the reserved debug bits at one
				n.words[hidx] = tbl_wdata_i;
				n.nv_wr = 1'b1;
				n.nv_addr = hidx;
				n.nv_wdata = tbl_wdata_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register; all words read erased until loaded
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			r <= '0;
			r.st <= CFM_ST_LOAD;
			r.words <= '1;
		end
		else
			r <= n;
	end

	// Outputs straight from flops
	assign tbl_rdata_o = r.rdata;
	assign tbl_ack_o = r.ack;
	assign tbl_err_o = r.err;
	assign nv_addr_o = r.nv_addr;
	assign nv_wr_o = r.nv_wr;
	assign nv_wdata_o = r.nv_wdata;
	assign cfg_words_o = r.cfg;
	assign osc_valid_o = r.osc_valid;
	assign sys_rst_n_o = r.sys_rst_n;

	////////////////////////////////////////////////////////////////////////
	// Checking helpers: counts observed during start-up
	logic [4:0] ld_cnt; // Cycles spent loading
	logic [CFM_TW-1:0] ost_edges; // Edges counted while waiting
	logic [CFM_TW-1:0] pwrt_cyc; // Cycles in the delay state
	logic [CFM_TW-1:0] pwrt_exp; // Delay that was loaded

	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			ld_cnt <= '0;
			ost_edges <= '0;
			pwrt_cyc <= '0;
			pwrt_exp <= '0;
		end
		else
		begin
			if (r.st == CFM_ST_LOAD)
				ld_cnt <= ld_cnt + 1'b1;
			if (r.st == CFM_ST_OST && osc_rise && !ost_done)
				ost_edges <= ost_edges + 1'b1;
			if (r.st == CFM_ST_PWRT)
				pwrt_cyc <= pwrt_cyc + 1'b1;
			if (pwrt_load)
				pwrt_exp <= pwrt_count;
		end
	end

	default clocking cfm_cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);

	sequence s_run_rd(logic [23:0] a);
		tbl_rd_i && !tbl_wr_i && r.st == CFM_ST_RUN && tbl_addr_i == a;
	endsequence

	a_erased_reads_one: assert property (
		s_run_rd(CFM_USER_UNIT_ID_BYTE0) ##0
		r.words[CFM_IDX_UID0] == 8'hff |=> tbl_rdata_o == 8'hff)
		else $error("erased word did not read all ones");

	a_base_word_map: assert property (
		s_run_rd(CFM_BOOT_SEGMENT_CONFIG) |=> tbl_ack_o && !tbl_err_o &&
		tbl_rdata_o == ($past(r.words[CFM_IDX_BOOT]) &
		CFM_IMPL_MASK[CFM_IDX_BOOT]))
		else $error("base address does not return the first word");

	a_space_guard: assert property (
		(tbl_rd_i || tbl_wr_i) && tbl_addr_i < CFM_SPACE_LO |=>
		tbl_ack_o && tbl_err_o && tbl_rdata_o == '0 && !nv_wr_o)
		else $error("access outside configuration space not refused");

	a_unimpl_zero: assert property (
		s_run_rd(CFM_GENERAL_SEGMENT_CONFIG) |=>
		(tbl_rdata_o & ~CFM_IMPL_MASK[CFM_IDX_GENERAL]) == '0)
		else $error("unimplemented bits read nonzero");

	a_small_secure: assert property (
		s_run_rd(CFM_SECURE_SEGMENT_CONFIG) ##0 small_s |=>
		tbl_rdata_o == CFM_ABSENT_DATA)
		else $error("absent secure word did not read 0xff");

	a_por_reserved: assert property (
		s_run_rd(CFM_POWER_ON_CONFIG) |=>
		(tbl_rdata_o & CFM_FORCE_ONE[CFM_IDX_POR]) ==
		CFM_FORCE_ONE[CFM_IDX_POR])
		else $error("reserved power-on bits not read as one");

	a_pwrt_length: assert property (
		$rose(sys_rst_n_o) |-> pwrt_cyc == pwrt_exp + 1'b1)
		else $error("power-up delay length wrong");

	a_ost_periods: assert property (
		$rose(osc_valid_o) |-> ost_edges == CFM_OST_PERIODS)
		else $error("oscillator wait not 1024 periods");

	a_load_first: assert property (
		$rose(sys_rst_n_o) |-> ld_cnt == 5'(CFM_NWORDS) && osc_valid_o)
		else $error("reset released before words were loaded");

	c_reach_run: cover property ($rose(sys_rst_n_o));
	c_cfg_write: cover property (tbl_wr_i && r.st == CFM_ST_RUN && hit);
	c_small_read: cover property (s_run_rd(CFM_SECURE_SEGMENT_CONFIG)
		##0 small_s);
	c_refused: cover property (tbl_rd_i && tbl_addr_i < CFM_SPACE_LO);

endmodule
`default_nettype wire

// file: cfm_pkg.sv
`default_nettype none
// Shared constants for the configuration word store
package cfm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Geometry
	localparam int CFM_NWORDS = 12;
	localparam int CFM_AW = 24;
	localparam int CFM_DW = 8;
	localparam int CFM_IW = 4;

	////////////////////////////////////////////////////////////////////////
	// Address map (byte addresses in program-memory space)
	localparam logic [23:0] CFM_SPACE_LO = 24'h800000;
	localparam logic [23:0] CFM_SPACE_HI = 24'hffffff;
	localparam logic [23:0] CFM_BOOT_SEGMENT_CONFIG = 24'hf80000;
	localparam logic [23:0] CFM_SECURE_SEGMENT_CONFIG = 24'hf80002;
	localparam logic [23:0] CFM_GENERAL_SEGMENT_CONFIG = 24'hf80004;
	localparam logic [23:0] CFM_OSC_SOURCE_SELECT_CONFIG = 24'hf80006;
	localparam logic [23:0] CFM_OSC_OPTIONS_CONFIG = 24'hf80008;
	localparam logic [23:0] CFM_WATCHDOG_CONFIG = 24'hf8000a;
	localparam logic [23:0] CFM_POWER_ON_CONFIG = 24'hf8000c;
	localparam logic [23:0] CFM_DEBUG_CONFIG = 24'hf8000e;
	localparam logic [23:0] CFM_USER_UNIT_ID_BYTE0 = 24'hf80010;
	localparam logic [23:0] CFM_USER_UNIT_ID_BYTE1 = 24'hf80012;
	localparam logic [23:0] CFM_USER_UNIT_ID_BYTE2 = 24'hf80014;
	localparam logic [23:0] CFM_USER_UNIT_ID_BYTE3 = 24'hf80016;
	localparam logic [11:0][23:0] CFM_WORD_ADDR = {
		CFM_USER_UNIT_ID_BYTE3, CFM_USER_UNIT_ID_BYTE2,
		CFM_USER_UNIT_ID_BYTE1, CFM_USER_UNIT_ID_BYTE0,
		CFM_DEBUG_CONFIG, CFM_POWER_ON_CONFIG, CFM_WATCHDOG_CONFIG,
		CFM_OSC_OPTIONS_CONFIG, CFM_OSC_SOURCE_SELECT_CONFIG,
		CFM_GENERAL_SEGMENT_CONFIG, CFM_SECURE_SEGMENT_CONFIG,
		CFM_BOOT_SEGMENT_CONFIG};

	// Word indices with special handling
	localparam logic [3:0] CFM_IDX_BOOT = 4'h0;
	localparam logic [3:0] CFM_IDX_SECURE = 4'h1;
	localparam logic [3:0] CFM_IDX_GENERAL = 4'h2;
	localparam logic [3:0] CFM_IDX_POR = 4'h6;
	localparam logic [3:0] CFM_IDX_UID0 = 4'h8;
	localparam logic [3:0] CFM_IDX_LAST = 4'hb;

	////////////////////////////////////////////////////////////////////////
	// Bit layout: implemented bits and bits that always read as one
	localparam logic [11:0][7:0] CFM_IMPL_MASK = {
		8'hff, 8'hff, 8'hff, 8'hff, 8'he3, 8'hf7,
		8'hdf, 8'he7, 8'h87, 8'h07, 8'hcf, 8'hcf};
	localparam logic [11:0][7:0] CFM_FORCE_ONE = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] CFM_ABSENT_DATA = 8'hff;
	localparam logic [7:0] CFM_UNMAPPED_DATA = 8'h00;
	localparam int CFM_PWRT_LSB = 0;
	localparam int CFM_PWRT_W = 3;

	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CFM_MCLK_HZ = 20000000;
	localparam int CFM_MS_PER_S = 1000;
	localparam int CFM_CYC_PER_MS = CFM_MCLK_HZ / CFM_MS_PER_S;
	localparam int CFM_TW = 24;
	// Power-up timer period in ms per field code
	localparam logic [7:0][7:0] CFM_PWRT_MS = {
		8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h00};
	// Oscillator periods before the clock counts as valid
	localparam logic [23:0] CFM_OST_PERIODS = 24'h000400;

	////////////////////////////////////////////////////////////////////////
	// Sequencer states
	typedef enum logic [3:0] {
		CFM_ST_LOAD = 4'h1,
		CFM_ST_OST = 4'h2,
		CFM_ST_PWRT = 4'h4,
		CFM_ST_RUN = 4'h8
	} cfm_state_type;

endpackage
`default_nettype wire

// file: cfm_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser for one asynchronous level
module cfm_sync
	import cfm_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic d_i,
	output logic q_o
);

	typedef struct packed {
		logic s1; // First stage, read only by the second
		logic s2; // Second stage, safe to use
	} cfm_sync_type;

	cfm_sync_type r;
	cfm_sync_type n;

	////////////////////////////////////////////////////////////////////////
	// Next state: shift the level through
	always_comb
	begin
		n = r;
		n.s1 = d_i;
		n.s2 = r.s1;
	end

	// State register
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			r <= '0;
		else
			r <= n;
	end

	assign q_o = r.s2;

endmodule
`default_nettype wire

// file: cfm_timer.sv
`timescale 1ns/1ps
`default_nettype none
// Down counter: loaded with a count, steps on each tick, flags done
module cfm_timer
	import cfm_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic load_i,
	input wire logic [CFM_TW-1:0] count_i,
	input wire logic tick_i,
	output logic done_o
);

	typedef struct packed {
		logic [CFM_TW-1:0] cnt; // Ticks still to come
		logic done; // Idle or expired
	} cfm_timer_type;

	cfm_timer_type r;
	cfm_timer_type n;

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb
	begin
		n = r;
		if (load_i)
		begin
			// A zero count expires at once
			n.cnt = count_i;
			n.done = (count_i == '0);
		end
		else if (tick_i && !r.done)
		begin
			n.cnt = r.cnt - 1'b1;
			n.done = (r.cnt == CFM_TW'(1));
		end
	end

	// State register; idle counts as done
	always_ff @(posedge mclk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			r <= '{cnt: '0, done: 1'b1};
		else
			r <= n;
	end

	assign done_o = r.done;

endmodule
`default_nettype wire

// file: cfm_config_fuse_map_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cfm_config_fuse_map_tb
	import cfm_pkg::*;
;
	////////////////////////////////////////////////////////////////////////
	// Stimulus and observed signals
	logic mclk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic osc_i = 1'b0;
	logic small_variant_i = 1'b0;
	logic tbl_rd_i = 1'b0;
	logic tbl_wr_i = 1'b0;
	logic [23:0] tbl_addr_i = 24'h000000;
	logic [7:0] tbl_wdata_i = 8'h00;
	wire logic [7:0] tbl_rdata_o;
	wire logic tbl_ack_o;
	wire logic tbl_err_o;
	wire logic [3:0] nv_addr_o;
	wire logic [7:0] nv_rdata_i;
	wire logic nv_wr_o;
	wire logic [7:0] nv_wdata_o;
	wire logic [95:0] cfg_words_o;
	wire logic osc_valid_o;
	wire logic sys_rst_n_o;
	// Storage model, sixteen deep so any index the design shows is legal
	logic [7:0] nv_mem [16];
	int fail_count = 0;
	int n_compared = 0;
	int osc_cnt = 0;
	// Power-up periods in ms per field code
	int tb_ms [8] = '{0, 2, 4, 8, 16, 32, 64, 128};

	// Short ms so eight power-up runs fit in the cycle budget
	cfm_config_fuse_map #(.PWRT_CYC_PER_MS(2)) u_cfm_config_fuse_map (
		.mclk_i(mclk_i), .rst_n_i(rst_n_i), .osc_i(osc_i),
		.small_variant_i(small_variant_i), .tbl_rd_i(tbl_rd_i),
		.tbl_wr_i(tbl_wr_i), .tbl_addr_i(tbl_addr_i),
		.tbl_wdata_i(tbl_wdata_i), .tbl_rdata_o(tbl_rdata_o),
		.tbl_ack_o(tbl_ack_o), .tbl_err_o(tbl_err_o),
		.nv_addr_o(nv_addr_o), .nv_rdata_i(nv_rdata_i),
		.nv_wr_o(nv_wr_o), .nv_wdata_o(nv_wdata_o),
		.cfg_words_o(cfg_words_o), .osc_valid_o(osc_valid_o),
		.sys_rst_n_o(sys_rst_n_o));

	////////////////////////////////////////////////////////////////////////
	// Clocks: oscillator pin is slower than half the system clock
	initial forever #25 mclk_i = ~mclk_i;
	initial forever #65 osc_i = ~osc_i;
	// Oscillator edge count, cleared by the bench when the wait opens
	always @(posedge osc_i) osc_cnt++;
	// Storage reads combinationally, takes write pulses on the edge
	assign nv_rdata_i = nv_mem[nv_addr_o];
	always @(posedge mclk_i)
	begin
		if (nv_wr_o === 1'b1)
			nv_mem[nv_addr_o] <= nv_wdata_o;
	end

	////////////////////////////////////////////////////////////////////////
	// Checking helpers
	task automatic chk(input string what, input logic [23:0] e,
			input logic [23:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("wrong value %s expected %0h seen %0h", what, e, g);
			fail_count++;
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Effective value: masked stored byte plus the bits held at one
	function automatic logic [7:0] eff(input int i);
		return (nv_mem[i] & CFM_IMPL_MASK[i]) | CFM_FORCE_ONE[i];
	endfunction

	// One table request; flags are ack, err, storage write pulse
	task automatic access(input logic wr, input logic [23:0] a,
			input logic [7:0] d, output logic [7:0] rdat,
			output logic [2:0] flags);
		@(negedge mclk_i);
		tbl_rd_i = ~wr;
		tbl_wr_i = wr;
		tbl_addr_i = a;
		tbl_wdata_i = d;
		@(negedge mclk_i);
		rdat = tbl_rdata_o;
		flags = {tbl_ack_o, tbl_err_o, nv_wr_o};
		tbl_rd_i = 1'b0;
		tbl_wr_i = 1'b0;
	endtask

	task automatic req_chk(input logic wr, input logic [23:0] a,
			input logic [7:0] d, input logic [2:0] ef, input logic [7:0] ed);
		logic [7:0] r;
		logic [2:0] f;
		access(wr, a, d, r, f);
		chk("answer flags", {21'h0, ef}, {21'h0, f});
		chk("read data", {16'h0, ed}, {16'h0, r});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset, load, oscillator wait and power-up delay for one code
	task automatic t_power_up(input int code);
		int n;
		nv_mem[6] = 8'h18 | code[7:0];
		@(negedge mclk_i);
		rst_n_i = 1'b0;
		repeat (16) @(negedge mclk_i);
		chk("held in reset", 24'h0, {22'h0, osc_valid_o, sys_rst_n_o});
		rst_n_i = 1'b1;
		repeat (12) @(negedge mclk_i);
		osc_cnt = 0;
		n = 0;
		while (osc_valid_o !== 1'b1 && n < 6000)
		begin
			@(negedge mclk_i);
			n++;
		end
		// Synchroniser latency blurs the count by a few edges
		chk("osc edges", 24'd1024, (osc_cnt >= 1023 && osc_cnt <= 1026) ?
			24'd1024 : osc_cnt[23:0]);
		// A wait that never ends counts as a mismatch; the run goes on
		if (n >= 6000)
			fail_count++;
		n = 0;
		while (sys_rst_n_o !== 1'b1 && n < 400)
		begin
			// A request while still held must be refused
			if (code != 0 && n == 0)
			begin
				tbl_rd_i = 1'b1;
				tbl_addr_i = CFM_BOOT_SEGMENT_CONFIG;
			end
			if (code != 0 && n == 1)
			begin
				chk("early refusal", 24'h000300,
					{14'h0, tbl_ack_o, tbl_err_o, tbl_rdata_o});
				tbl_rd_i = 1'b0;
			end
			@(negedge mclk_i);
			n++;
		end
		chk("power-up cycles", 24'(2 * tb_ms[code] + 1), n[23:0]);
		if (n >= 400)
			fail_count++;
	endtask

	// Every word read back at its even address and on the word bus
	task automatic t_read_all();
		for (int i = 0; i < CFM_NWORDS; i++)
		begin
			req_chk(1'b0, CFM_WORD_ADDR[i], 8'h00, 3'b100, eff(i));
			chk("word bus", eff(i), cfg_words_o[8*i +: 8]);
		end
	endtask

	// Outside the space, odd and past-the-end addresses
	task automatic t_refuse();
		req_chk(1'b0, 24'h7fffff, 8'h00, 3'b110, 8'h00);
		req_chk(1'b1, 24'h7ffffe, 8'h55, 3'b110, 8'h00);
		req_chk(1'b0, 24'hf80001, 8'h00, 3'b100, 8'h00);
		req_chk(1'b0, 24'hf80018, 8'h00, 3'b100, 8'h00);
	endtask

	// Writes reach storage; reserved bits keep their fixed reading
	task automatic t_write();
		req_chk(1'b1, CFM_POWER_ON_CONFIG, 8'h00, 3'b101, 8'h00);
		chk("storage index", 24'h6, {20'h0, nv_addr_o});
		chk("storage data", 24'h0, {16'h0, nv_wdata_o});
		req_chk(1'b0, CFM_POWER_ON_CONFIG, 8'h00, 3'b100, 8'he0);
		chk("word bus por", 24'he0, {16'h0, cfg_words_o[55:48]});
		// Debug reserved bits are always written as one; all-ones
		// also shows the unimplemented bits masked on read
		req_chk(1'b1, CFM_DEBUG_CONFIG, 8'hff, 3'b101, 8'h00);
		req_chk(1'b0, CFM_DEBUG_CONFIG, 8'h00, 3'b100, 8'he3);
		// A fully erased word reads all ones
		req_chk(1'b1, CFM_USER_UNIT_ID_BYTE0, 8'hff, 3'b101, 8'h00);
		req_chk(1'b0, CFM_USER_UNIT_ID_BYTE0, 8'h00, 3'b100, 8'hff);
		req_chk(1'b1, CFM_USER_UNIT_ID_BYTE3, 8'h00, 3'b101, 8'h00);
		req_chk(1'b0, CFM_USER_UNIT_ID_BYTE3, 8'h00, 3'b100, 8'h00);
	endtask

	// Smallest variant hides the secure word
	task automatic t_small();
		small_variant_i = 1'b1;
		repeat (4) @(negedge mclk_i);
		req_chk(1'b0, CFM_SECURE_SEGMENT_CONFIG, 8'h00, 3'b100, 8'hff);
		small_variant_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		req_chk(1'b0, CFM_SECURE_SEGMENT_CONFIG, 8'h00, 3'b100, eff(1));
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		// Mixed ones and zeros so both bit states appear in each word
		for (int i = 0; i < 16; i++)
			nv_mem[i] = 8'h3c + 8'h17 * i[7:0];
		for (int c = 0; c < 8; c++)
			t_power_up(c);
		t_read_all();
		t_refuse();
		t_write();
		t_small();
		summarize();
	end

endmodule
`default_nettype wire
